// *** hw/cos_regs.vh ***
// Register map, field positions, reset values and timing constants of the CANopen supervisor.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
`ifndef COS_REGS_VH
`define COS_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define COS_REG_CTRL 12'h000
`define COS_REG_NODE 12'h004
`define COS_REG_SYNC 12'h008
`define COS_REG_HBP 12'h00c
`define COS_REG_SDOT 12'h010
`define COS_REG_STAT 12'h014
`define COS_REG_IRQ 12'h018
`define COS_REG_MASK 12'h01c
`define COS_REG_CMD 12'h020
`define COS_REG_NST 12'h024
`define COS_REG_SYNCID 12'h028
`define COS_REG_WIN 12'h02c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define COS_CTRL_PROTO 0
`define COS_CTRL_CFG 1
`define COS_CTRL_SYNCEN 2
`define COS_CTRL_HBEN 3
`define COS_CTRL_CONT 4
`define COS_CTRL_RST 32'h0000_0000
`define COS_NODE_RST 8'h01

// Command register fields
`define COS_CMD_SDO 0
`define COS_CMD_HBCLR 1

// Event bits
`define COS_EV_HBTO 0
`define COS_EV_SDOTO 1
`define COS_EV_SDOERR 2
`define COS_EV_RESET 3
`define COS_EV_W 4

// ----------------------------------------
// Fixed protocol values and node states
// ----------------------------------------
`define COS_SYNC_COBID 11'h080
`define COS_SYNC_WIN 32'h0000_0000
`define COS_ST_INIT 8'h00
`define COS_ST_STOP 8'h04
`define COS_ST_OPER 8'h05
`define COS_ST_PREOP 8'h7f
`define COS_ST_OFF 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define COS_CLK_HZ 25000000
`define COS_MS_NS 1000000
`define COS_CLK_NS 40
`define COS_MS_CYC (`COS_MS_NS / `COS_CLK_NS)
`define COS_SYNC_MS 16'd200
`define COS_HB_MS 16'd300
`define COS_SDO_MS 16'd500
`define COS_SLOW_MS 800
`define COS_SINGLE_MS 1200
`define COS_DOUBLE_MS 1600
`define COS_PULSE_MS 200
`define COS_HB_NUM 5
`define COS_HB_DEN 2

`endif

// *** hw/cos_flash.v ***
// Lamp pattern generator: slow, single and double flash phases from a millisecond tick.
// Assumes a one-cycle ms_tick from the supervisor on the same clock.
`include "cos_regs.vh"

module cos_flash (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    input wire ms_tick,
    // Pattern outputs
    output reg slow,
    output reg single,
    output reg dbl
);

reg [10:0] cnt_slow;
reg [10:0] cnt_single;
reg [10:0] cnt_dbl;

// ----------------------------------------
// Pattern counters
// ----------------------------------------
always @(posedge sys_clk) begin
    if (!rstn) begin
        cnt_slow <= 11'h000;
        cnt_single <= 11'h000;
        cnt_dbl <= 11'h000;
        slow <= 1'b0;
        single <= 1'b0;
        dbl <= 1'b0;
    end else begin
        if (ms_tick) begin
            cnt_slow <= (cnt_slow == `COS_SLOW_MS - 1) ? 11'h000 : cnt_slow + 11'h001;
            cnt_single <= (cnt_single == `COS_SINGLE_MS - 1) ? 11'h000 : cnt_single + 11'h001;
            cnt_dbl <= (cnt_dbl == `COS_DOUBLE_MS - 1) ? 11'h000 : cnt_dbl + 11'h001;
        end
        // Half on, half off
        slow <= (cnt_slow < `COS_SLOW_MS / 2);
        // One equal pulse per period
        single <= (cnt_single < `COS_PULSE_MS);
        // Two equal pulses with dark gap
        dbl <= (cnt_dbl < `COS_PULSE_MS) ||
            ((cnt_dbl >= 2 * `COS_PULSE_MS) && (cnt_dbl < 3 * `COS_PULSE_MS));
    end
end

endmodule

// *** hw/cos_supervisor.v ***
// CANopen node supervisor: role select, lamps, SYNC and heartbeat timers, SDO timeout.
// Assumes an APB master on sys_clk and a CAN controller providing status pins.
//
// How it works
// - Run steady operational; both slow-flash pre-operational
// - Run single-flash stopped, otherwise dark
// - Error lamp dark normally, steady bus-off
// - Error single-flash on error warning
// - Error double-flash on heartbeat timeout
// - Protocol on: master if configuration present
// - Master when master number equals own
// - SYNC pulse every configured period, 200 ms
// - SYNC identifier fixed at 0x80
// - Synchronous window fixed at zero
// - Only one SYNC producer on network
// - Heartbeat pulse every production period, 300 ms
// - Consumer timeout 2.5 periods raises event
// - Each SDO frame waits SDO timeout
// - Missing SDO reply flags configuration timeout
// - SDO error: continue or broadcast reset
// - Record node state from heartbeat
`include "cos_regs.vh"

module cos_supervisor (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // CAN controller status (asynchronous)
    input wire can_bus_off,
    input wire can_err_warn,
    // Received frame events (same clock)
    input wire hb_rx,
    input wire [7:0] hb_rx_state,
    input wire sdo_reply,
    input wire sdo_reply_err,
    // Frame requests
    output reg sync_tx,
    output wire [10:0] sync_cobid,
    output reg hb_tx,
    output reg nmt_reset_tx,
    // Node state
    output wire is_master,
    output wire [7:0] local_state,
    // Lamps and interrupt
    output reg run_lamp,
    output reg err_lamp,
    output wire irq
);

// ----------------------------------------
// Functions
// ----------------------------------------
function [31:0] ms_to_cyc_limit;
    input [15:0] ms;
    begin
        ms_to_cyc_limit = (ms == 16'h0000) ? 32'h0000_0000 : {16'h0000, ms};
    end
endfunction

function [31:0] hb_timeout_ms;
    input [15:0] ms;
    begin
        hb_timeout_ms = ({16'h0000, ms} * `COS_HB_NUM) / `COS_HB_DEN;
    end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [2:0] boff_sync;
reg [2:0] warn_sync;
reg bus_off;
reg err_warn;

always @(posedge sys_clk) begin
    if (!rstn) begin
        boff_sync <= 3'h0;
        warn_sync <= 3'h0;
        bus_off <= 1'b0;
        err_warn <= 1'b0;
    end else begin
        boff_sync <= {boff_sync[1:0], can_bus_off};
        warn_sync <= {warn_sync[1:0], can_err_warn};
        if (boff_sync[1] == boff_sync[2])
            bus_off <= boff_sync[2];
        if (warn_sync[1] == warn_sync[2])
            err_warn <= warn_sync[2];
    end
end

// ----------------------------------------
// Millisecond tick
// ----------------------------------------
reg [15:0] ms_div;
wire ms_tick = (ms_div == `COS_MS_CYC - 1);

always @(posedge sys_clk) begin
    if (!rstn)
        ms_div <= 16'h0000;
    else if (ms_tick)
        ms_div <= 16'h0000;
    else
        ms_div <= ms_div + 16'h0001;
end

// ----------------------------------------
// Registers
// ----------------------------------------
reg [31:0] ctrl;
reg [7:0] own_node;
reg [7:0] master_node;
reg [15:0] sync_ms;
reg [15:0] hb_ms;
reg [15:0] sdo_ms;
reg [`COS_EV_W-1:0] irq_stat;
reg [`COS_EV_W-1:0] irq_mask;
reg [7:0] node_state;
reg hb_to_active;
reg sdo_busy;

wire wr = psel && penable && pwrite;
wire rd = psel && penable && !pwrite;
wire mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (paddr <= `COS_REG_WIN);
wire cmd_wr = wr && (paddr == `COS_REG_CMD);
wire sdo_start = cmd_wr && pwdata[`COS_CMD_SDO];

assign pready = 1'b1;
assign pslverr = psel && penable && !mapped;

// Role from protocol enable, configuration and node numbers
assign is_master = ctrl[`COS_CTRL_PROTO] && ctrl[`COS_CTRL_CFG]
    && (master_node == own_node);
assign sync_cobid = `COS_SYNC_COBID;
assign local_state = node_state;

always @(posedge sys_clk) begin
    if (!rstn) begin
        ctrl <= `COS_CTRL_RST;
        own_node <= `COS_NODE_RST;
        master_node <= `COS_NODE_RST;
        sync_ms <= `COS_SYNC_MS;
        hb_ms <= `COS_HB_MS;
        sdo_ms <= `COS_SDO_MS;
        irq_mask <= {`COS_EV_W{1'b0}};
    end else if (wr) begin
        case (paddr)
            `COS_REG_CTRL: ctrl <= {27'h0, pwdata[4:0]};
            `COS_REG_NODE: begin
                own_node <= pwdata[7:0];
                master_node <= pwdata[15:8];
            end
            `COS_REG_SYNC: sync_ms <= pwdata[15:0];
            `COS_REG_HBP: hb_ms <= pwdata[15:0];
            `COS_REG_SDOT: sdo_ms <= pwdata[15:0];
            `COS_REG_MASK: irq_mask <= pwdata[`COS_EV_W-1:0];
            default: ;
        endcase
    end
end

always @(posedge sys_clk) begin
    if (!rstn) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
        case (paddr)
            `COS_REG_CTRL: prdata <= ctrl;
            `COS_REG_NODE: prdata <= {16'h0000, master_node, own_node};
            `COS_REG_SYNC: prdata <= {16'h0000, sync_ms};
            `COS_REG_HBP: prdata <= {16'h0000, hb_ms};
            `COS_REG_SDOT: prdata <= {16'h0000, sdo_ms};
            `COS_REG_STAT: prdata <= {26'h0, sdo_busy, hb_to_active, err_warn, bus_off,
                is_master, ctrl[`COS_CTRL_PROTO]};
            `COS_REG_IRQ: prdata <= {28'h0, irq_stat};
            `COS_REG_MASK: prdata <= {28'h0, irq_mask};
            `COS_REG_NST: prdata <= {24'h0, node_state};
            `COS_REG_SYNCID: prdata <= {21'h0, `COS_SYNC_COBID};
            `COS_REG_WIN: prdata <= `COS_SYNC_WIN;
            default: prdata <= 32'h0000_0000;
        endcase
    end
end

// ----------------------------------------
// SYNC and heartbeat producers
// ----------------------------------------
reg [15:0] sync_cnt;
reg [15:0] hb_cnt;
// Only the master produces SYNC, one producer per network
wire sync_on = ctrl[`COS_CTRL_SYNCEN] && is_master;
wire hb_on = ctrl[`COS_CTRL_HBEN] && ctrl[`COS_CTRL_PROTO];

always @(posedge sys_clk) begin
    if (!rstn) begin
        sync_cnt <= 16'h0000;
        hb_cnt <= 16'h0000;
        sync_tx <= 1'b0;
        hb_tx <= 1'b0;
    end else begin
        sync_tx <= 1'b0;
        hb_tx <= 1'b0;
        if (!sync_on) begin
            sync_cnt <= 16'h0000;
        end else if (ms_tick) begin
            if ({16'h0000, sync_cnt} + 32'h1 >= ms_to_cyc_limit(sync_ms)) begin
                sync_cnt <= 16'h0000;
                sync_tx <= 1'b1;
            end else begin
                sync_cnt <= sync_cnt + 16'h0001;
            end
        end
        if (!hb_on) begin
            hb_cnt <= 16'h0000;
        end else if (ms_tick) begin
            if ({16'h0000, hb_cnt} + 32'h1 >= ms_to_cyc_limit(hb_ms)) begin
                hb_cnt <= 16'h0000;
                hb_tx <= 1'b1;
            end else begin
                hb_cnt <= hb_cnt + 16'h0001;
            end
        end
    end
end

// ----------------------------------------
// Heartbeat consumer and node state
// ----------------------------------------
reg [17:0] hbc_cnt;
reg hbc_armed;
reg hb_to_ev;

always @(posedge sys_clk) begin
    if (!rstn) begin
        hbc_cnt <= 18'h00000;
        hbc_armed <= 1'b0;
        hb_to_active <= 1'b0;
        hb_to_ev <= 1'b0;
        node_state <= `COS_ST_INIT;
    end else begin
        hb_to_ev <= 1'b0;
        if (hb_rx) begin
            hbc_cnt <= 18'h00000;
            hbc_armed <= 1'b1;
            hb_to_active <= 1'b0;
            node_state <= hb_rx_state;
        end else begin
            if (cmd_wr && pwdata[`COS_CMD_HBCLR])
                hb_to_active <= 1'b0;
            if (hbc_armed && is_master && ms_tick) begin
                if (hbc_cnt + 18'h1 >= hb_timeout_ms(hb_ms)) begin
                    hbc_armed <= 1'b0;
                    hb_to_active <= 1'b1;
                    hb_to_ev <= 1'b1;
                    node_state <= `COS_ST_OFF;
                end else begin
                    hbc_cnt <= hbc_cnt + 18'h00001;
                end
            end
        end
    end
end

// ----------------------------------------
// SDO per-frame timeout
// ----------------------------------------
reg [15:0] sdo_cnt;
reg sdo_to_ev;
reg sdo_err_ev;

always @(posedge sys_clk) begin
    if (!rstn) begin
        sdo_busy <= 1'b0;
        sdo_cnt <= 16'h0000;
        sdo_to_ev <= 1'b0;
        sdo_err_ev <= 1'b0;
        nmt_reset_tx <= 1'b0;
    end else begin
        sdo_to_ev <= 1'b0;
        sdo_err_ev <= 1'b0;
        nmt_reset_tx <= 1'b0;
        if (sdo_start && is_master) begin
            sdo_busy <= 1'b1;
            sdo_cnt <= 16'h0000;
        end else if (sdo_busy && sdo_reply) begin
            // Reply expected for each frame
            sdo_busy <= 1'b0;
            if (sdo_reply_err) begin
                sdo_err_ev <= 1'b1;
                nmt_reset_tx <= !ctrl[`COS_CTRL_CONT];
            end
        end else if (sdo_busy && ms_tick) begin
            if ({16'h0000, sdo_cnt} + 32'h1 >= ms_to_cyc_limit(sdo_ms)) begin
                sdo_busy <= 1'b0;
                sdo_to_ev <= 1'b1;
                nmt_reset_tx <= !ctrl[`COS_CTRL_CONT];
            end else begin
                sdo_cnt <= sdo_cnt + 16'h0001;
            end
        end
    end
end

// ----------------------------------------
// Interrupt status, cleared by read, set wins
// ----------------------------------------
wire [`COS_EV_W-1:0] ev = {nmt_reset_tx, sdo_err_ev, sdo_to_ev, hb_to_ev};
wire irq_rd = rd && (paddr == `COS_REG_IRQ);

always @(posedge sys_clk) begin
    if (!rstn)
        irq_stat <= {`COS_EV_W{1'b0}};
    else
        irq_stat <= (irq_rd ? {`COS_EV_W{1'b0}} : irq_stat) | ev;
end

assign irq = |(irq_stat & irq_mask);

// ----------------------------------------
// Lamps
// ----------------------------------------
wire fl_slow;
wire fl_single;
wire fl_dbl;

cos_flash u_flash (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ms_tick(ms_tick),
    .slow(fl_slow),
    .single(fl_single),
    .dbl(fl_dbl)
);

always @(posedge sys_clk) begin
    if (!rstn) begin
        run_lamp <= 1'b0;
        err_lamp <= 1'b0;
    end else begin
        case (node_state)
            `COS_ST_OPER: run_lamp <= 1'b1;
            `COS_ST_PREOP: run_lamp <= fl_slow;
            `COS_ST_STOP: run_lamp <= fl_single;
            default: run_lamp <= 1'b0;
        endcase
        if (bus_off)
            err_lamp <= 1'b1;
        else if (hb_to_active)
            err_lamp <= fl_dbl;
        else if (err_warn)
            err_lamp <= fl_single;
        else if (node_state == `COS_ST_PREOP)
            err_lamp <= fl_slow;
        else
            err_lamp <= 1'b0;
    end
end

endmodule

// *** bench/cos_sup_asserts.sv ***
// Port checker of the supervisor.
// Bound to cos_supervisor; sees its ports only.
`include "cos_regs.vh"
module cos_sup_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Status and frames
    input wire logic can_bus_off,
    input wire logic hb_rx,
    input wire logic [7:0] hb_rx_state,
    input wire logic sync_tx,
    input wire logic [10:0] sync_cobid,
    input wire logic hb_tx,
    input wire logic nmt_reset_tx,
    input wire logic is_master,
    input wire logic [7:0] local_state,
    input wire logic err_lamp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire rd = psel && penable && !pwrite;

    a_sync_id_fixed: assert property (sync_cobid == `COS_SYNC_COBID)
        else $error("sync id changed");
    a_syncid_read: assert property (rd && paddr == `COS_REG_SYNCID |-> prdata == 32'h80)
        else $error("sync id read wrong");
    a_window_zero: assert property (rd && paddr == `COS_REG_WIN |-> prdata == 32'h0)
        else $error("window not zero");
    a_sync_master: assert property (sync_tx |-> is_master ##1 !sync_tx [*8])
        else $error("sync pulse wrong");
    a_hb_single: assert property (hb_tx |=> !hb_tx [*8])
        else $error("heartbeat pulse wrong");
    a_reset_pulse: assert property (nmt_reset_tx |=> !nmt_reset_tx [*8])
        else $error("reset pulse wrong");
    a_state_record: assert property (hb_rx |=> local_state == $past(hb_rx_state))
        else $error("node state not recorded");
    a_busoff_lamp: assert property (can_bus_off [*8] |-> err_lamp)
        else $error("bus-off lamp dark");
endmodule

bind cos_supervisor cos_sup_asserts i_chk (.sys_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .prdata, .can_bus_off, .hb_rx, .hb_rx_state, .sync_tx, .sync_cobid, .hb_tx,
    .nmt_reset_tx, .is_master, .local_state, .err_lamp);

// *** bench/cos_slave_model.sv ***
// Behavioural CANopen slave: heartbeats and SDO replies.
// Assumes the bench flags each SDO request on sdo_go.
module cos_slave_model #(
    parameter int HB_CYC = 12500,
    parameter int DLY = 20
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bench control; mode 0 silent, 1 good, 2 error
    input wire logic hb_on,
    input wire logic [7:0] hb_state,
    input wire logic sdo_go,
    input wire logic [1:0] sdo_mode,
    // Frames to the supervisor
    output logic hb_rx = 1'b0,
    output logic [7:0] hb_rx_state = 8'h5a,
    output logic sdo_reply = 1'b0,
    output logic sdo_reply_err = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int hb_n = 0;
    int sdo_n = 0;
    logic [1:0] mode = 2'd0;

    // No SYNC output: slaves leave SYNC to the master
    always @(posedge sys_clk) begin
        hb_rx <= 1'b0;
        sdo_reply <= 1'b0;
        hb_rx_state <= ~hb_rx_state;
        sdo_reply_err <= ~sdo_reply_err;
        if (!rstn || !hb_on) begin
            hb_n <= 0;
        end else if (hb_n == HB_CYC - 1) begin
            hb_n <= 0;
            hb_rx <= 1'b1;
            hb_rx_state <= hb_state;
        end else begin
            hb_n <= hb_n + 1;
        end
        if (!rstn) begin
            sdo_n <= 0;
        end else if (sdo_go && sdo_mode != 2'd0) begin
            sdo_n <= DLY;
            mode <= sdo_mode;
        end else if (sdo_n == 1) begin
            sdo_n <= 0;
            sdo_reply <= 1'b1;
            sdo_reply_err <= (mode == 2'd2);
        end else if (sdo_n != 0) begin
            sdo_n <= sdo_n - 1;
        end
    end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the supervisor beside a slave model.
// Assumes the design, the model and the checker compiled first.
`include "cos_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic can_bus_off = 1'b0, can_err_warn = 1'b0, hb_on = 1'b0, sdo_go = 1'b0;
    logic [1:0] sdo_mode = 2'd0;
    wire [31:0] prdata;
    wire pready, pslverr, hb_rx, sdo_reply, sdo_reply_err, sync_tx, hb_tx, nmt_reset_tx;
    wire is_master, run_lamp, err_lamp, irq;
    wire [7:0] hb_rx_state, local_state;
    wire [10:0] sync_cobid;
    int num_errors = 0;
    int checks = 0;
    time t_off;
    always #20 sys_clk = ~sys_clk;

    cos_supervisor i_cos_supervisor (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .can_bus_off, .can_err_warn, .hb_rx,
        .hb_rx_state, .sdo_reply, .sdo_reply_err, .sync_tx, .sync_cobid, .hb_tx,
        .nmt_reset_tx, .is_master, .local_state, .run_lamp, .err_lamp, .irq);
    cos_slave_model i_cos_slave_model (.sys_clk, .rstn, .hb_on, .hb_state(8'h05),
        .sdo_go, .sdo_mode, .hb_rx, .hb_rx_state, .sdo_reply, .sdo_reply_err);

    // ----
    // Shared tasks
    // ----
    task close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task bad(input string m);
        num_errors++;
        $display("wrong value at %0t ns: %s", $time, m);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            bad(m);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad("bus hang");
            close_out;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, x, m);
    endtask
    task wait_ev(input int which, input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((which == 0 ? nmt_reset_tx : irq) !== 1'b1 && n < lim);
        if (n >= lim) begin
            bad("event never came");
            close_out;
        end
    endtask
    task sdo_start(input logic [1:0] m);
        wr(`COS_REG_CMD, 32'h1);
        sdo_mode <= m;
        sdo_go <= 1'b1;
        @(posedge sys_clk);
        sdo_go <= 1'b0;
    endtask

    // ----
    // Scenarios
    // ----
    task s_regs;
        chk({run_lamp, err_lamp, irq}, 32'h0, "lamps at reset");
        rd_chk(`COS_REG_NODE, 32'h0101, "node numbers");
        rd_chk(`COS_REG_SYNC, 32'hc8, "sync period");
        rd_chk(`COS_REG_HBP, 32'h12c, "hb period");
        rd_chk(`COS_REG_SDOT, 32'h1f4, "sdo timeout");
        wr(`COS_REG_SYNCID, 32'h123);
        rd_chk(`COS_REG_SYNCID, 32'h80, "sync id");
        wr(`COS_REG_WIN, 32'h5);
        rd_chk(`COS_REG_WIN, 32'h0, "window");
        apb(1'b0, 12'h040, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk(e, 32'h1, "unmapped error");
    endtask
    task s_role;
        logic [31:0] ctl [4] = '{32'h1, 32'h3, 32'h3, 32'h2};
        logic [31:0] nod [4] = '{32'h0101, 32'h0101, 32'h0201, 32'h0101};
        logic x [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            wr(`COS_REG_NODE, nod[i]);
            wr(`COS_REG_CTRL, ctl[i]);
            @(posedge sys_clk);
            chk(is_master, x[i], "role");
            rd_chk(`COS_REG_STAT, {x[i], ctl[i][0]}, "role status");
        end
    endtask
    task s_timers;
        int t [2][2];
        int k [2];
        wr(`COS_REG_SYNC, 32'h1);
        wr(`COS_REG_HBP, 32'h1);
        wr(`COS_REG_SDOT, 32'h1);
        wr(`COS_REG_MASK, 32'hf);
        wr(`COS_REG_CTRL, 32'hf);
        hb_on <= 1'b1;
        k = '{0, 0};
        t = '{'{0, 0}, '{0, 0}};
        for (int i = 0; i < 52000 && (k[0] < 2 || k[1] < 2); i++) begin
            @(posedge sys_clk);
            if (sync_tx === 1'b1 && k[0] < 2) begin
                t[0][k[0]] = i;
                k[0]++;
            end
            if (hb_tx === 1'b1 && k[1] < 2) begin
                t[1][k[1]] = i;
                k[1]++;
            end
        end
        chk(t[0][1] - t[0][0], `COS_MS_CYC, "sync interval");
        chk(t[1][1] - t[1][0], `COS_MS_CYC, "hb interval");
        chk(local_state, 32'h5, "node state");
        chk(run_lamp, 32'h1, "run lamp operational");
    endtask
    task s_sdo;
        int n;
        sdo_start(2'd1);
        repeat (40) @(posedge sys_clk);
        rd_chk(`COS_REG_IRQ, 32'h0, "answered request");
        sdo_start(2'd0);
        wait_ev(0, 26000, n);
        chk(n <= 25002, 32'h1, "sdo wait length");
        repeat (2) @(posedge sys_clk);
        chk(irq, 32'h1, "irq raised");
        rd_chk(`COS_REG_IRQ, 32'ha, "timeout events");
        @(posedge sys_clk);
        chk(irq, 32'h0, "irq cleared");
        wr(`COS_REG_MASK, 32'h1);
        wr(`COS_REG_CTRL, 32'h1f);
        sdo_start(2'd2);
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            n += (nmt_reset_tx === 1'b1);
        end
        chk(n, 32'h0, "reset despite continue");
        chk(irq, 32'h0, "masked event");
        rd_chk(`COS_REG_IRQ, 32'h4, "sdo error event");
    endtask
    task s_hb;
        int n;
        hb_on <= 1'b0;
        t_off = $time;
        wait_ev(1, 80000, n);
        chk(($time - t_off) > 500000 && ($time - t_off) <= 3000000, 32'h1, "hb wait");
        chk(local_state, 32'hff, "offline state");
        rd_chk(`COS_REG_IRQ, 32'h1, "hb timeout event");
    endtask
    task s_lamp;
        can_bus_off <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(err_lamp, 32'h1, "bus-off lamp");
        rd_chk(`COS_REG_STAT, 32'h17, "bus-off status");
        can_bus_off <= 1'b0;
        can_err_warn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd_chk(`COS_REG_STAT, 32'h1b, "warning status");
        wr(`COS_REG_CMD, 32'h2);
        can_err_warn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd_chk(`COS_REG_STAT, 32'h3, "errors cleared");
        chk(err_lamp, 32'h0, "error lamp dark");
        chk(run_lamp, 32'h0, "run lamp offline");
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        s_regs;
        s_role;
        s_timers;
        s_sdo;
        s_hb;
        s_lamp;
        close_out;
    end
endmodule
